/* logic/rcs_defs.svh */
// Purpose: constants for the remote counter word interface
// Assumes: word indices are relative to the selected bank
// Notes:   timing counts are in 5 ns clock cycles
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// word indices within a bank, and the bank shift
`define RCS_W_HIGH       3'h0
`define RCS_W_LOW        3'h1
`define RCS_W_EXTRA      3'h2
`define RCS_W_STATUS     3'h3
`define RCS_W_DIAG       3'h4
`define RCS_W_CMD        3'h0
`define RCS_W_PAR1       3'h1
`define RCS_W_PAR2       3'h2
`define RCS_BANK_SHIFT   4'h8

// command codes
`define RCS_CMD_NONE     16'h0000
`define RCS_CMD_THR1     16'h0001
`define RCS_CMD_THR2     16'h0002
`define RCS_CMD_SETPT    16'h0003
`define RCS_CMD_WINDOW   16'h0004
`define RCS_CMD_CLEAR    16'h0005
`define RCS_CMD_LOAD     16'h0006

// reset values
`define RCS_WINDOW_RESET 8'h02
`define RCS_COUNT_RESET  32'h0000_0000

// 16-bit wrap points of the low word, 32-bit wrap points of the whole count
`define RCS_LOW_MAX      16'h7fff
`define RCS_LOW_MIN      16'h8000
`define RCS_CNT_MAX      32'h7fff_ffff
`define RCS_CNT_MIN      32'h8000_0000

// timing: self-initialisation and command execution, in cycles
`define RCS_INIT_CYCLES  1000
`define RCS_CMD_CYCLES   4

`endif

/* logic/rcs_pkg.sv */
// Purpose: types of the remote counter word interface
// Assumes: nothing
// Notes:   constants live in rcs_defs.svh
`default_nettype none
package rcs_pkg;
  typedef enum logic [1:0] {st_init, st_idle, st_busy} rcs_state_t;
endpackage
`default_nettype wire

/* logic/rcs_counter.sv */
// Purpose: word interface and count logic of a remote high-speed counter
// Assumes: all inputs synchronous to clk; modes 1 to 3 (32-bit counting)
// Notes:   one-cycle read latency; commands run after a fixed delay
// Operation
// R1: after init, counter and thresholds are zero and target window is two
// R2: error indicator lit during self-initialisation, dark afterwards
// R3: zero pulse acts only while reference point input is on, modes 1-3
// R4: switch seven off counts all encoder edges times four
// R5: switch five picks x2/x1, switch six rising/falling, only with seven on
// R6: status bit 0 reads 0 while a command runs, 1 when free
// R7: status bits 1-4 show set, reset, reference point, count valid inputs
// R8: status bits 8-13 show the six comparison results in order
// R9: status bit 14 shows count direction, 1 means incrementing
// R10: count valid off forces binary outputs low, status stays live
// R11: diagnosis bits 0-6 flag short circuit on each output
// R12: over-temperature sets diagnosis bit 7 and forces outputs to zero
// R13: diagnosis bit 15 flags counter range overflow or excess count rate
// R14: diagnosis bit 8 reads 0 for 32-bit, 1 for two 16-bit words
// R15: in two-word mode high word counts low-word overflows, signed
// R16: low wrap up increments high word, wrap down decrements it
// R17: five input and three output words, base switch shifts index by 8
// R18: diagnosis bits 9-13 show rear switch positions, 1 means on
// R19: host writes zero command before each new command, waits for free
// R20: unused status bits and diagnosis bit 14 read zero
`timescale 1ns/1ps
`include "rcs_defs.svh"
`default_nettype none
module rcs_counter #(
  parameter int INIT_CYCLES = `RCS_INIT_CYCLES,
  parameter int CMD_CYCLES  = `RCS_CMD_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // field bus words
  input  wire logic [3:0]  rd_idx,
  output logic      [15:0] rd_data,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  // base switches: bank select, 32-bit (1) or two-word (0)
  input  wire logic        base_bank_hi,
  input  wire logic        base_single32,
  // rear switches 1 to 8
  input  wire logic [8:1]  rear_sw,
  // counting and binary inputs
  input  wire logic        chan_a,
  input  wire logic        chan_b,
  input  wire logic        chan_c,
  input  wire logic        set_in,
  input  wire logic        reset_in,
  input  wire logic        reference_point_input,
  input  wire logic        count_valid,
  // protection sensing
  input  wire logic [6:0]  short_sense,
  input  wire logic        over_temp,
  input  wire logic        rate_high,
  // physical outputs
  output logic      [6:0]  bin_out,
  output logic             error_led
);

  // bank-relative word offset; bit 3 flags an index inside the bank
  function automatic logic [3:0] word_off(input logic [3:0] idx,
                                          input logic       hi);
    logic [3:0] rel;
    rel = idx - (hi ? `RCS_BANK_SHIFT : 4'h0);
    word_off = {(rel <= 4'h4), rel[2:0]};
  endfunction

  function automatic logic edge_ok(input logic prev, input logic cur,
                                   input logic all, input logic fall);
    edge_ok = (prev != cur) && (all || (cur == !fall));
  endfunction

  // returns {gt, eq}; equal means inside +/- half the target window
  function automatic logic [1:0] cmp(input logic [31:0] v,
                                     input logic [31:0] t,
                                     input logic [7:0]  win);
    logic signed [32:0] diff;
    logic signed [32:0] half;
    diff = $signed({v[31], v}) - $signed({t[31], t});
    half = $signed({26'h0, win[7:1]});
    cmp  = {(diff > half), (diff >= -half) && (diff <= half)};
  endfunction

  rcs_pkg::rcs_state_t state_r;
  logic [15:0] timer_r;
  logic [15:0] cmd_r;
  logic        armed_r;
  logic [15:0] par1_r;
  logic [15:0] par2_r;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] thr1_r;
  logic [31:0] thr2_r;
  logic [31:0] setpt_r;
  logic [7:0]  win_r;
  logic        dir_r;
  logic        ovf_r;
  logic        a_p;
  logic        b_p;
  logic        c_p;
  logic        set_p;

  // write decode
  wire [3:0] wr_off   = word_off(wr_idx, base_bank_hi);
  wire       wr_cmd   = wr_en && wr_off[3] && wr_off[2:0] == `RCS_W_CMD;
  wire       wr_par1  = wr_en && wr_off[3] && wr_off[2:0] == `RCS_W_PAR1;
  wire       wr_par2  = wr_en && wr_off[3] && wr_off[2:0] == `RCS_W_PAR2;
  wire       cmd_zero = wr_data == `RCS_CMD_NONE;
  // a new command is taken only after a zero command and while free
  wire       cmd_take = wr_cmd && !cmd_zero && armed_r &&
                        state_r == rcs_pkg::st_idle;  // [R19]
  wire       cmd_exec = state_r == rcs_pkg::st_busy && timer_r == 16'h0;
  wire       running  = state_r != rcs_pkg::st_init;

  // edge qualification
  wire sel_all = !rear_sw[7];
  wire a_any   = a_p != chan_a;
  wire b_any   = b_p != chan_b;
  wire a_sel   = rear_sw[5] ? edge_ok(a_p, chan_a, 1'b0, rear_sw[6])
                            : a_any;                          // [R5]
  wire enc_dir = chan_a ^ b_p;
  // encoder: all edges of both channels, or channel A only with sw7 on
  wire enc_ev  = sel_all ? (a_any || b_any) : a_sel;          // [R4]
  // a leading b counts up; testing against previous b serves both channels
  wire enc_up  = enc_ev && enc_dir;
  wire enc_dn  = enc_ev && !enc_up;
  wire ud_up   = edge_ok(a_p, chan_a, sel_all, rear_sw[6]);
  wire ud_dn   = edge_ok(b_p, chan_b, sel_all, rear_sw[6]);
  wire raw_up  = rear_sw[8] ? ud_up : enc_up;
  wire raw_dn  = rear_sw[8] ? ud_dn : enc_dn;
  wire inc_ev  = rear_sw[4] ? raw_dn : raw_up;
  wire dec_ev  = rear_sw[4] ? raw_up : raw_dn;
  wire step_up = running && count_valid && inc_ev && !dec_ev;
  wire step_dn = running && count_valid && dec_ev && !inc_ev;

  // zero pulse: falling C edge clears only with reference point on
  wire zero_ev = running && count_valid && reference_point_input &&
                 c_p && !chan_c;                              // [R3]
  wire set_ev  = running && count_valid && set_in && !set_p;

  // step arithmetic; two-word mode carries low-word wraps upward
  wire        two_word = !base_single32;
  wire [15:0] lo       = cnt_r[15:0];
  wire [15:0] hi       = cnt_r[31:16];
  wire        lo_top   = lo == `RCS_LOW_MAX;
  wire        lo_bot   = lo == `RCS_LOW_MIN;
  wire [15:0] hi_up    = hi + {15'h0, lo_top};                // [R16]
  wire [15:0] hi_dn    = hi - {15'h0, lo_bot};                // [R16]
  wire [31:0] cnt_up   = two_word ? {hi_up, lo + 16'h1}
                                  : cnt_r + 32'h1;            // [R15]
  wire [31:0] cnt_dn   = two_word ? {hi_dn, lo - 16'h1}
                                  : cnt_r - 32'h1;
  wire wrap32 = !two_word && ((step_up && cnt_r == `RCS_CNT_MAX) ||
                              (step_dn && cnt_r == `RCS_CNT_MIN));

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (cmd_exec && cmd_r == `RCS_CMD_CLEAR)
      cnt_nxt = `RCS_COUNT_RESET;
    else if (cmd_exec && cmd_r == `RCS_CMD_LOAD)
      cnt_nxt = {par1_r, par2_r};
    else if (running && reset_in)
      cnt_nxt = `RCS_COUNT_RESET;
    else if (set_ev)
      cnt_nxt = setpt_r;
    else if (zero_ev)
      cnt_nxt = `RCS_COUNT_RESET;
    else if (step_up)
      cnt_nxt = cnt_up;
    else if (step_dn)
      cnt_nxt = cnt_dn;
  end

  // comparisons; two-word mode compares the signed low word
  wire [31:0] cmp_val = two_word ? {{16{lo[15]}}, lo} : cnt_r;
  wire [1:0]  c_zero  = cmp(cmp_val, 32'h0, win_r);
  wire [1:0]  c_thr1  = cmp(cmp_val, thr1_r, win_r);
  wire [1:0]  c_thr2  = cmp(cmp_val, thr2_r, win_r);
  wire [6:0]  out_int = {dir_r, c_thr2[1], c_thr2[0], c_thr1[1],
                         c_thr1[0], c_zero[1], c_zero[0]};

  // status and diagnosis words
  wire [15:0] stat_w = {1'b0, out_int, 3'h0,                  // [R20]
                        count_valid, reference_point_input,
                        reset_in, set_in,                     // [R7]
                        state_r == rcs_pkg::st_idle};         // [R6] [R8]
  wire [15:0] diag_w = {ovf_r, 1'b0,                          // [R13] [R20]
                        rear_sw[4], rear_sw[5], rear_sw[8],
                        rear_sw[7], rear_sw[6],               // [R18]
                        two_word,                             // [R14]
                        over_temp, short_sense};              // [R11] [R12]
  wire [3:0]  rd_off = word_off(rd_idx, base_bank_hi);
  logic [15:0] rd_mux;

  always_comb
  begin
    rd_mux = 16'h0;
    if (rd_off[3])
    begin
      unique case (rd_off[2:0])
        `RCS_W_HIGH:   rd_mux = hi;
        `RCS_W_LOW:    rd_mux = lo;
        `RCS_W_EXTRA:  rd_mux = hi;
        `RCS_W_STATUS: rd_mux = stat_w;
        default:       rd_mux = diag_w;
      endcase
    end
  end

  // state machine: init, then idle/busy per command
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= rcs_pkg::st_init;
      timer_r <= 16'(INIT_CYCLES - 1);
    end
    else
    begin
      unique case (state_r)
        rcs_pkg::st_init:
          if (timer_r == 16'h0)
            state_r <= rcs_pkg::st_idle;
          else
            timer_r <= timer_r - 16'h1;
        rcs_pkg::st_idle:
          if (cmd_take)
          begin
            state_r <= rcs_pkg::st_busy;
            timer_r <= 16'(CMD_CYCLES - 1);
          end
        rcs_pkg::st_busy:
          if (timer_r == 16'h0)
            state_r <= rcs_pkg::st_idle;
          else
            timer_r <= timer_r - 16'h1;
      endcase
    end
  end

  // bus words and command effects; reset gives the power-on values
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      armed_r <= 1'b0;
      cmd_r   <= `RCS_CMD_NONE;
      par1_r  <= 16'h0;
      par2_r  <= 16'h0;
      thr1_r  <= `RCS_COUNT_RESET;                            // [R1]
      thr2_r  <= `RCS_COUNT_RESET;                            // [R1]
      setpt_r <= `RCS_COUNT_RESET;
      win_r   <= `RCS_WINDOW_RESET;                           // [R1]
    end
    else
    begin
      if (wr_cmd && cmd_zero)
        armed_r <= 1'b1;
      else if (cmd_take)
        armed_r <= 1'b0;
      if (cmd_take)
        cmd_r <= wr_data;
      if (wr_par1)
        par1_r <= wr_data;
      if (wr_par2)
        par2_r <= wr_data;
      if (cmd_exec && cmd_r == `RCS_CMD_THR1)
        thr1_r <= {par1_r, par2_r};
      if (cmd_exec && cmd_r == `RCS_CMD_THR2)
        thr2_r <= {par1_r, par2_r};
      if (cmd_exec && cmd_r == `RCS_CMD_SETPT)
        setpt_r <= {par1_r, par2_r};
      if (cmd_exec && cmd_r == `RCS_CMD_WINDOW)
        win_r <= par2_r[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= `RCS_COUNT_RESET;                              // [R1]
      dir_r <= 1'b1;
      a_p   <= 1'b0;
      b_p   <= 1'b0;
      c_p   <= 1'b0;
      set_p <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      a_p   <= chan_a;
      b_p   <= chan_b;
      c_p   <= chan_c;
      set_p <= set_in;
      if (step_up || step_dn)
        dir_r <= step_up;                                     // [R9]
    end
  end

  // overflow is sticky; a clear or load command drops it, but an event
  // in the same cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ovf_r <= 1'b0;
    else if (wrap32 || rate_high)
      ovf_r <= 1'b1;                                          // [R13]
    else if (cmd_exec && (cmd_r == `RCS_CMD_CLEAR ||
                          cmd_r == `RCS_CMD_LOAD))
      ovf_r <= 1'b0;
  end

  // outputs registered; valid off or overheat forces all binary outputs low
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bin_out   <= 7'h0;
      error_led <= 1'b1;
      rd_data   <= 16'h0;
    end
    else
    begin
      bin_out   <= (count_valid && !over_temp && running)
                   ? out_int : 7'h0;                          // [R10] [R12]
      error_led <= state_r == rcs_pkg::st_init;               // [R2]
      rd_data   <= rd_mux;                                    // [R17]
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_init_led_lit: assert property ( // [R2]
    state_r == rcs_pkg::st_init |=> error_led)
    else $error("error led dark during init");
  a_init_values: assert property ( // [R1]
    $rose(running) |-> cnt_r == 32'h0 && thr1_r == 32'h0 &&
                       thr2_r == 32'h0 && win_r == 8'h02)
    else $error("power-on values wrong after init");
  a_cmd_busy_free: assert property ( // [R6]
    cmd_take |=> !stat_w[0] [*4] ##1 stat_w[0])
    else $error("transfer status not busy then free");
  a_valid_gates_out: assert property ( // [R10]
    !count_valid |=> bin_out == 7'h0)
    else $error("outputs driven while count valid off");
  a_overtemp_gates: assert property ( // [R12]
    over_temp |=> bin_out == 7'h0 && $past(diag_w[7]))
    else $error("overheat did not force outputs off");
  a_low_wrap_up: assert property ( // [R16]
    two_word && step_up && lo == 16'h7fff && cnt_nxt == cnt_up
    |=> hi == $past(hi) + 16'h1 && lo == 16'h8000)
    else $error("high word not incremented on low wrap");
  a_low_wrap_down: assert property ( // [R16]
    two_word && step_dn && lo == 16'h8000 && cnt_nxt == cnt_dn
    |=> hi == $past(hi) - 16'h1 && lo == 16'h7fff)
    else $error("high word not decremented on low wrap");
  a_overflow_flag: assert property ( // [R13]
    (wrap32 || rate_high) |=> ovf_r && diag_w[15])
    else $error("overflow not flagged");
  a_status_read: assert property ( // [R17]
    rd_off[3] && rd_off[2:0] == 3'h3 |=> rd_data == $past(stat_w))
    else $error("status word read back wrong");

  c_command_run: cover property (cmd_take ##5 stat_w[0]);
  c_two_word_wrap: cover property (two_word && step_up && lo_top);
  c_zero_pulse: cover property (zero_ev && cnt_r != 32'h0);
  c_overheat: cover property (over_temp && count_valid);

endmodule
`default_nettype wire

/* testbench/rcs_host.sv */
// Purpose: central unit model driving the counter unit word bus
// Assumes: one-cycle write strobes, read data one cycle after index
// Notes:   idle write data shows the inverse of the last word
`timescale 1ns/1ps
`include "rcs_defs.svh"
`default_nettype none
module rcs_host (
  // clock
  input  wire logic        clk,
  // field bus words
  output logic      [3:0]  rd_idx,
  input  wire logic [15:0] rd_data,
  output logic             wr_en,
  output logic      [3:0]  wr_idx,
  output logic      [15:0] wr_data
);
  initial
  begin
    rd_idx  = 4'h0;
    wr_en   = 1'b0;
    wr_idx  = 4'h0;
    wr_data = 16'h0000;
  end

  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_idx  <= i;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    // a released bus must not keep showing the old word
    wr_data <= ~d;
  endtask

  task automatic rd(input logic [3:0] i, output logic [15:0] d);
    @(posedge clk);
    rd_idx <= i;
    @(posedge clk);
    #1 d = rd_data;
  endtask

  // params, then zero to arm, then the command, then poll the free flag
  task automatic cmd(input logic [3:0] b, input logic [15:0] c,
                     input logic [15:0] p1, input logic [15:0] p2,
                     output logic ok);
    logic [15:0] s;
    wr(b + `RCS_W_PAR1, p1);
    wr(b + `RCS_W_PAR2, p2);
    wr(b + `RCS_W_CMD, `RCS_CMD_NONE);
    wr(b + `RCS_W_CMD, c);
    ok = 1'b0;
    for (int k = 0; k < 20 && !ok; k++)
    begin
      rd(b + `RCS_W_STATUS, s);
      ok = (s[0] === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/test_rcs_counter.sv */
// Purpose: self-checking bench of the counter unit word interface
// Assumes: init shortened to 8 cycles
// Notes:   channel b moves only in the quadrature test
`timescale 1ns/1ps
`include "rcs_defs.svh"
`default_nettype none
module test_rcs_counter;
  logic        clk;
  logic        rst_n;
  logic [3:0]  rd_idx;
  logic [15:0] rd_data;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [15:0] wr_data;
  logic        bank_hi;
  logic        single32;
  logic [8:1]  rear_sw;
  logic        chan_a;
  logic        chan_b;
  logic        chan_c;
  logic        set_in;
  logic        reset_in;
  logic        ref_pt;
  logic        valid;
  logic [6:0]  short_sense;
  logic        over_temp;
  logic        rate_high;
  logic [6:0]  bin_out;
  logic        error_led;
  logic [15:0] v;
  logic        ok;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [8:1]  sw_tab [6] = '{8'h80, 8'hc0, 8'he0, 8'h88, 8'h50, 8'h70};
  logic [15:0] ex_tab [6] = '{16'h0006, 16'h0003, 16'h0003, 16'hfffa,
                              16'h0003, 16'hfffd};

  rcs_counter #(.INIT_CYCLES(8), .CMD_CYCLES(`RCS_CMD_CYCLES)) rcs_counter_i (
    .clk(clk), .rst_n(rst_n), .rd_idx(rd_idx), .rd_data(rd_data),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .base_bank_hi(bank_hi), .base_single32(single32), .rear_sw(rear_sw),
    .chan_a(chan_a), .chan_b(chan_b), .chan_c(chan_c), .set_in(set_in),
    .reset_in(reset_in), .reference_point_input(ref_pt),
    .count_valid(valid), .short_sense(short_sense), .over_temp(over_temp),
    .rate_high(rate_high), .bin_out(bin_out), .error_led(error_led));

  rcs_host rcs_host_i (
    .clk(clk), .rd_idx(rd_idx), .rd_data(rd_data), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rdw(input logic [3:0] i, output logic [15:0] d);
    rcs_host_i.rd((bank_hi ? `RCS_BANK_SHIFT : 4'h0) + i, d);
  endtask

  task automatic cmd(input logic [15:0] c, p1, p2);
    rcs_host_i.cmd(bank_hi ? `RCS_BANK_SHIFT : 4'h0, c, p1, p2, ok);
    chk("cmd free", {15'h0, ok}, 16'h0001);
  endtask

  task automatic pulse_a(input int n);
    repeat (n)
    begin
      @(posedge clk) chan_a <= 1'b1;
      repeat (2) @(posedge clk);
      chan_a <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic words(input logic [15:0] eh, el);
    rdw(`RCS_W_HIGH, v);
    chk("high word", v, eh);
    rdw(`RCS_W_EXTRA, v);
    chk("extra word", v, eh);
    rdw(`RCS_W_LOW, v);
    chk("low word", v, el);
  endtask

  function automatic logic [15:0] diag(input logic ovf);
    return {ovf, 1'b0, rear_sw[4], rear_sw[5], rear_sw[8], rear_sw[7],
            rear_sw[6], ~single32, over_temp, short_sense};
  endfunction

  task automatic diag_case(input logic [8:1] sw, input logic [6:0] ss,
                           input logic ot, input logic s32);
    @(posedge clk);
    rear_sw     <= sw;
    short_sense <= ss;
    over_temp   <= ot;
    single32    <= s32;
    repeat (3) @(posedge clk);
    #1 chk("gated out", {9'h0, bin_out}, ot ? 16'h0 : 16'h0055);
    rdw(`RCS_W_DIAG, v);
    chk("diag", v, diag(1'b0));
  endtask

  initial
  begin
    {rst_n, bank_hi, chan_a, chan_b, chan_c, set_in, reset_in} = '0;
    {ref_pt, valid, short_sense, over_temp, rate_high} = '0;
    single32 = 1'b1;
    rear_sw  = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("led init", {15'h0, error_led}, 16'h0001);
    rdw(`RCS_W_STATUS, v);
    chk("init busy", v & 16'h0001, 16'h0000);
    repeat (12) @(posedge clk);
    #1 chk("led off", {15'h0, error_led}, 16'h0000);
    words(16'h0000, 16'h0000);
    rdw(`RCS_W_STATUS, v);
    chk("status rst", v, 16'h5501);
    chk("invalid out", {9'h0, bin_out}, 16'h0000);
    $display("test init done");
    @(posedge clk) {set_in, reset_in, ref_pt, valid} <= 4'hf;
    repeat (3) @(posedge clk);
    rdw(`RCS_W_STATUS, v);
    chk("status in", v, 16'h551f);
    diag_case(8'h4a, 7'h2a, 1'b1, 1'b1);
    diag_case(8'hb5, 7'h55, 1'b0, 1'b0);
    @(posedge clk) {set_in, reset_in, ref_pt, single32} <= 4'h1;
    $display("test status done");
    @(posedge clk) bank_hi <= 1'b1;
    rcs_host_i.rd(`RCS_W_STATUS, v);
    chk("old bank", v, 16'h0000);
    cmd(`RCS_CMD_LOAD, 16'h0001, 16'h0002);
    words(16'h0001, 16'h0002);
    @(posedge clk) bank_hi <= 1'b0;
    rcs_host_i.wr(`RCS_W_PAR2, 16'h0009);
    rcs_host_i.wr(`RCS_W_CMD, `RCS_CMD_LOAD);
    rdw(`RCS_W_STATUS, v);
    chk("refused", v & 16'h0001, 16'h0001);
    rdw(`RCS_W_LOW, v);
    chk("refused low", v, 16'h0002);
    rcs_host_i.wr(`RCS_W_CMD, `RCS_CMD_NONE);
    rcs_host_i.wr(`RCS_W_CMD, `RCS_CMD_LOAD);
    rdw(`RCS_W_STATUS, v);
    chk("busy", v & 16'h0001, 16'h0000);
    repeat (8) @(posedge clk);
    rdw(`RCS_W_LOW, v);
    chk("loaded", v, 16'h0009);
    $display("test bus done");
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk) rear_sw <= sw_tab[k];
      cmd(`RCS_CMD_CLEAR, 16'h0, 16'h0);
      pulse_a(3);
      rdw(`RCS_W_LOW, v);
      chk("count", v, ex_tab[k]);
    end
    rdw(`RCS_W_STATUS, v);
    chk("status down", v, 16'h0011);
    @(posedge clk) rear_sw <= 8'h00;
    cmd(`RCS_CMD_CLEAR, 16'h0, 16'h0);
    for (int k = 1; k < 5; k++)
    begin
      @(posedge clk) {chan_b, chan_a} <= k[1:0] ^ (k[1:0] >> 1);
      repeat (2) @(posedge clk);
    end
    rdw(`RCS_W_LOW, v);
    chk("quad x4", v, 16'h0004);
    cmd(`RCS_CMD_LOAD, 16'h0000, 16'h0032);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) ref_pt <= k[0];
      chan_c <= 1'b1;
      repeat (2) @(posedge clk);
      chan_c <= 1'b0;
      repeat (3) @(posedge clk);
      rdw(`RCS_W_LOW, v);
      chk("zero pulse", v, k ? 16'h0000 : 16'h0032);
    end
    $display("test count done");
    @(posedge clk) {single32, rear_sw} <= {1'b0, 8'h50};
    cmd(`RCS_CMD_LOAD, 16'h0000, 16'h7fff);
    pulse_a(1);
    words(16'h0001, 16'h8000);
    @(posedge clk) rear_sw <= 8'h70;
    pulse_a(1);
    words(16'h0000, 16'h7fff);
    @(posedge clk) {single32, rear_sw} <= {1'b1, 8'h50};
    cmd(`RCS_CMD_LOAD, 16'h7fff, 16'hffff);
    pulse_a(1);
    rdw(`RCS_W_DIAG, v);
    chk("wrap flag", v, diag(1'b1));
    cmd(`RCS_CMD_CLEAR, 16'h0, 16'h0);
    rdw(`RCS_W_DIAG, v);
    chk("flag clear", v, diag(1'b0));
    @(posedge clk) rate_high <= 1'b1;
    @(posedge clk) rate_high <= 1'b0;
    rdw(`RCS_W_DIAG, v);
    chk("rate flag", v, diag(1'b1));
    $display("test words done");
    cmd(`RCS_CMD_THR1, 16'h0000, 16'h0010);
    cmd(`RCS_CMD_THR2, 16'h0000, 16'h0020);
    cmd(`RCS_CMD_WINDOW, 16'h0000, 16'h0006);
    cmd(`RCS_CMD_SETPT, 16'h0000, 16'h0012);
    @(posedge clk) set_in <= 1'b1;
    @(posedge clk) set_in <= 1'b0;
    repeat (2) @(posedge clk);
    rdw(`RCS_W_STATUS, v);
    chk("compare", v, 16'h4619);
    chk("compare out", {9'h0, bin_out}, 16'h0046);
    $display("test compare done");
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("led reinit", {15'h0, error_led}, 16'h0001);
    repeat (12) @(posedge clk);
    words(16'h0000, 16'h0000);
    rdw(`RCS_W_STATUS, v);
    chk("status rst2", v, 16'h5519);
    $display("test reset done");
    close_out();
  end

  // whole run is a few hundred cycles
  initial
  begin
    #100us;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
